// File: core/hbp_cfg.svh
// Constants and functional notes for the host bus port with DMA requests.
// Functional notes
// - Port is eight bits; multiplexed mode takes address then data on shared lines.
// - Non-multiplexed mode takes address from separate lines, data on separate lines.
// - Indirect option in non-multiplexed mode decodes only the lowest address line.
// - Both separate read/write strobes and data strobe with direction are supported.
// - Separate-strobe convention: asserted read strobe means a register read.
// - Separate-strobe convention: asserted write strobe means a register write.
// - Data-strobe convention: rising edge of the data strobe ends the access.
// - Direction line high means read, low means write.
// - Register accesses are answered only while chip select is low.
// - Multiplexed mode captures the address while address latch enable is high.
// - Address latch enable also selects multiplexed or non-multiplexed operation.
// - Interrupt request is active low, open drain, never driven high.
// - Transmit request rises on start with a nonzero count, then while bytes remain and the transmit FIFO has room; it holds until a block's last byte.
// - Transmit moves full 64-byte blocks then one remainder block until count reached.
// - Transmit request drops right after the falling edge of the write strobe of a block's last byte.
// - Receive request drops right after the falling edge of the read strobe of a block's last byte.
// - First-channel DMA requests exist only in terminal-equipment mode; the port holds them low in every mode.
// - With DMA acknowledge low, address is ignored and strobes select FIFO top.
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH
`define HBP_DW        8
`define HBP_BLOCK     7'h40
`define HBP_FIFO_D    8
`define HBP_FIFO_AW   3
`define HBP_SYNC_N    3
// Synchroniser idle levels: strobes, select and acknowledge high, latch enable low.
`define HBP_SYNC_RST  6'h3B
`define HBP_BC_W      12
`endif

// File: core/hbp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and registered read data.
`timescale 1ns/1ps
`include "hbp_cfg.svh"
module hbp_fifo #(
  parameter int WIDTH = `HBP_DW,
  parameter int DEPTH = `HBP_FIFO_D,
  parameter int AW    = `HBP_FIFO_AW
) (
  // Clock and control.
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [AW:0]      level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire              head_load = (cnt != '0) && (!out_valid || pop);
  assign in_ready = (cnt + {{AW{1'b0}}, out_valid}) < (AW+1)'(DEPTH);
  assign level    = cnt + {{AW{1'b0}}, out_valid};
  // Head word sits in a register so the drain sees flop-driven data.
  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (ce) begin
      if (push) begin
        mem[wp] <= in_data;
        wp <= wp + 1'b1;
      end
      if (head_load) begin
        out_data <= mem[rp];
        rp <= rp + 1'b1;
      end
      out_valid <= head_load || (out_valid && !pop);
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, head_load};
    end
  end
endmodule : hbp_fifo

// File: core/hbp_pkg.sv
// Types shared by the host bus port files.
package hbp_pkg;
  typedef enum logic [2:0] {
    HBP_IDLE   = 3'b001,
    HBP_ACCESS = 3'b010,
    HBP_DONE   = 3'b100
  } hbp_state_t;
endpackage : hbp_pkg

// File: core/hbp_port.sv
// Host bus port: register access decode, transmit and receive DMA requests.
`timescale 1ns/1ps
`include "hbp_cfg.svh"
module hbp_port #(
  parameter int DW  = `HBP_DW,
  parameter int BCW = `HBP_BC_W
) (
  // Clock, reset and enable.
  input  wire logic           CLK,
  input  wire logic           RST,
  input  wire logic           CE,
  // Configuration straps.
  input  wire logic           INDIRECT_MODE,
  input  wire logic           DATA_STROBE_MODE,
  input  wire logic           TERMINAL_EQUIPMENT_MODE,
  // Host strobes, all asynchronous.
  input  wire logic           CS_N,
  input  wire logic           RD_N,
  input  wire logic           WR_N,
  input  wire logic           ALE,
  input  wire logic           DMA_ACK_N,
  // Shared and separate lines.
  input  wire logic [DW-1:0]  SHARED_ADDR_DATA_LINES_IN,
  output logic      [DW-1:0]  SHARED_ADDR_DATA_LINES_OUT,
  output logic                SHARED_ADDR_DATA_LINES_OE,
  input  wire logic [DW-1:0]  SEPARATE_ADDRESS_LINES,
  input  wire logic [DW-1:0]  SEPARATE_DATA_LINES_IN,
  output logic      [DW-1:0]  SEPARATE_DATA_LINES_OUT,
  output logic                SEPARATE_DATA_LINES_OE,
  // Register side toward the internal controllers.
  output logic                REG_WR,
  output logic                REG_RD,
  output logic      [DW-1:0]  REG_ADDR,
  output logic      [DW-1:0]  REG_WDATA,
  input  wire logic [DW-1:0]  REG_RDATA,
  // Transmit FIFO drain and receive FIFO fill.
  input  wire logic [BCW-1:0] TX_BYTE_COUNT,
  input  wire logic           TX_START,
  output logic                TX_VALID,
  input  wire logic           TX_READY,
  output logic      [DW-1:0]  TX_DATA,
  input  wire logic           RX_VALID,
  output logic                RX_READY,
  input  wire logic [DW-1:0]  RX_DATA,
  input  wire logic [6:0]     RX_BLOCK,
  // Interrupt and DMA requests.
  input  wire logic           IRQ_PENDING,
  output logic                INT_N_OUT,
  output logic                INT_N_OE,
  output logic                TX_DMA_REQ_CHAN_TWO,
  output logic                RX_DMA_REQ_CHAN_TWO,
  output logic                TX_DMA_REQ_CHAN_ONE,
  output logic                RX_DMA_REQ_CHAN_ONE
);
  // ****************************************************************
  // Strobe synchronisation
  // ****************************************************************
  logic [5:0] s;
  hbp_sync #(.W(6)) u_sync (
    .clk      (CLK),
    .rst      (RST),
    .ce       (CE),
    .async_in ({CS_N, RD_N, WR_N, ALE, DMA_ACK_N, 1'b1}),
    .rst_val  (`HBP_SYNC_RST),
    .sync_out (s)
  );
  wire cs_n  = s[5];
  wire rd_n  = s[4];
  wire wr_n  = s[3];
  wire ale   = s[2];
  wire ack_n = s[1];
  logic rd_n_q;
  logic wr_n_q;
  logic ale_q;
  logic muxed;
  logic rd_n_q_dir;
  // In data-strobe mode the read strobe pin carries the strobe and the write pin the direction.
  wire strobe_act = DATA_STROBE_MODE ? !rd_n : (!rd_n || !wr_n);
  wire is_read    = DATA_STROBE_MODE ? wr_n : !rd_n;
  wire is_write   = !wr_n;
  wire ds_rise    = DATA_STROBE_MODE && rd_n && !rd_n_q;
  wire selected   = !cs_n;
  wire dma_acc    = !ack_n;
  // The address is taken when the latch enable is first seen high, while the lines
  // still carry it; the synchroniser delay would otherwise let data overwrite it.
  wire ale_rise   = ale && !ale_q;
  wire [DW-1:0] data_in = muxed ? SHARED_ADDR_DATA_LINES_IN : SEPARATE_DATA_LINES_IN;
  wire [DW-1:0] sep_addr = INDIRECT_MODE ? {{(DW-1){1'b0}}, SEPARATE_ADDRESS_LINES[0]}
                                         : SEPARATE_ADDRESS_LINES;
  logic [DW-1:0] mux_addr;
  wire [DW-1:0] addr = muxed ? mux_addr : sep_addr;
  // ****************************************************************
  // Access sequencing
  // ****************************************************************
  hbp_pkg::hbp_state_t state;
  hbp_pkg::hbp_state_t next_state;
  wire start   = strobe_act && (selected || dma_acc);
  wire finish  = DATA_STROBE_MODE ? ds_rise : !strobe_act;
  // Write data are taken as the access starts: the host may release them before the
  // delayed strobe end reaches the state machine.
  wire wr_end  = (state == hbp_pkg::HBP_ACCESS) && finish && !rd_n_q_dir;
  wire rd_fall = !DATA_STROBE_MODE ? (!rd_n && rd_n_q) : 1'b0;
  wire rd_rise = !DATA_STROBE_MODE ? (rd_n && !rd_n_q) : 1'b0;
  wire wr_fall = !DATA_STROBE_MODE ? (!wr_n && wr_n_q) : 1'b0;
  always_comb begin
    next_state = state;
    unique case (state)
      hbp_pkg::HBP_IDLE:   if (start) next_state = hbp_pkg::HBP_ACCESS;
      hbp_pkg::HBP_ACCESS: if (finish) next_state = hbp_pkg::HBP_DONE;
      hbp_pkg::HBP_DONE:   next_state = hbp_pkg::HBP_IDLE;
      default:             next_state = hbp_pkg::HBP_IDLE;
    endcase
  end
  wire entering  = (state == hbp_pkg::HBP_IDLE) && start;
  wire dma_tx_wr = entering && dma_acc && is_write;
  wire dma_rx_rd = entering && dma_acc && is_read;
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= hbp_pkg::HBP_IDLE;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      muxed <= 1'b0;
      ale_q <= 1'b0;
      mux_addr <= '0;
      rd_n_q_dir <= 1'b0;
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
      REG_ADDR <= '0;
      REG_WDATA <= '0;
    end else if (CE) begin
      state <= next_state;
      rd_n_q <= rd_n;
      wr_n_q <= wr_n;
      ale_q <= ale;
      if (ale) begin
        muxed <= 1'b1;
      end
      if (ale_rise) begin
        mux_addr <= SHARED_ADDR_DATA_LINES_IN;
      end
      if (entering) begin
        rd_n_q_dir <= is_read;
        REG_ADDR <= addr;
      end
      REG_RD <= entering && is_read && selected && !dma_acc;
      REG_WR <= wr_end && selected && !dma_acc;
      if (entering && is_write) begin
        REG_WDATA <= data_in;
      end
    end
  end
  // ****************************************************************
  // Data lines and interrupt
  // ****************************************************************
  wire drive = (state != hbp_pkg::HBP_IDLE) && rd_n_q_dir && (selected || dma_acc) && strobe_act;
  logic [DW-1:0] rx_head;
  wire [DW-1:0] rdata = dma_acc ? rx_head : REG_RDATA;
  always_ff @(posedge CLK) begin
    if (RST) begin
      SHARED_ADDR_DATA_LINES_OUT <= '0;
      SHARED_ADDR_DATA_LINES_OE <= 1'b0;
      SEPARATE_DATA_LINES_OUT <= '0;
      SEPARATE_DATA_LINES_OE <= 1'b0;
      INT_N_OUT <= 1'b0;
      INT_N_OE <= 1'b0;
    end else if (CE) begin
      SHARED_ADDR_DATA_LINES_OUT <= rdata;
      SEPARATE_DATA_LINES_OUT <= rdata;
      SHARED_ADDR_DATA_LINES_OE <= drive && muxed;
      SEPARATE_DATA_LINES_OE <= drive && !muxed;
      INT_N_OUT <= 1'b0;
      INT_N_OE <= IRQ_PENDING;
    end
  end
  // ****************************************************************
  // Transmit DMA: host writes into the FIFO, drained toward the controller
  // ****************************************************************
  logic [BCW-1:0] tx_left;
  logic [6:0]     tx_blk;
  wire            tx_in_ready;
  wire [`HBP_FIFO_AW:0] tx_level;
  wire [BCW-1:0]  blk_full = BCW'(`HBP_BLOCK);
  wire            tx_last = (tx_blk == 7'h01) || (tx_left == BCW'(1));
  wire            tx_want = (tx_left != '0) && tx_in_ready;
  hbp_fifo u_tx_fifo (
    .clk       (CLK),
    .rst       (RST),
    .ce        (CE),
    .in_valid  (wr_fall && dma_acc && TX_DMA_REQ_CHAN_TWO),
    .in_ready  (tx_in_ready),
    .in_data   (data_in),
    .out_valid (TX_VALID),
    .out_ready (TX_READY),
    .out_data  (TX_DATA),
    .level     (tx_level)
  );
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_left <= '0;
      tx_blk <= '0;
      TX_DMA_REQ_CHAN_TWO <= 1'b0;
    end else if (CE) begin
      if (TX_START) begin
        tx_left <= TX_BYTE_COUNT;
        tx_blk <= (TX_BYTE_COUNT > blk_full) ? `HBP_BLOCK : 7'(TX_BYTE_COUNT);
        TX_DMA_REQ_CHAN_TWO <= TX_BYTE_COUNT != '0;
      end else if (wr_fall && dma_acc && TX_DMA_REQ_CHAN_TWO) begin
        tx_left <= tx_left - BCW'(1);
        tx_blk <= tx_blk - 7'h01;
        if (tx_last) begin
          TX_DMA_REQ_CHAN_TWO <= 1'b0;
          tx_blk <= ((tx_left - BCW'(1)) > blk_full) ? `HBP_BLOCK
                    : 7'(tx_left - BCW'(1));
        end
      end else if (!TX_DMA_REQ_CHAN_TWO && tx_want && tx_blk != '0) begin
        TX_DMA_REQ_CHAN_TWO <= 1'b1;
      end
    end
  end
  // ****************************************************************
  // Receive DMA: controller fills the FIFO, host reads the head
  // ****************************************************************
  logic [6:0] rx_blk;
  wire        rx_valid_int;
  wire [`HBP_FIFO_AW:0] rx_level;
  logic       rx_pend;
  // The head leaves the FIFO only when the read strobe ends, so the byte stays on
  // the lines for the whole read; the request itself still drops at the strobe start.
  wire        rx_take = rd_fall && dma_acc && RX_DMA_REQ_CHAN_TWO;
  wire        rx_pop  = rx_pend && rd_rise;
  hbp_fifo u_rx_fifo (
    .clk       (CLK),
    .rst       (RST),
    .ce        (CE),
    .in_valid  (RX_VALID),
    .in_ready  (RX_READY),
    .in_data   (RX_DATA),
    .out_valid (rx_valid_int),
    .out_ready (rx_pop),
    .out_data  (rx_head),
    .level     (rx_level)
  );
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_blk <= '0;
      rx_pend <= 1'b0;
      RX_DMA_REQ_CHAN_TWO <= 1'b0;
    end else if (CE) begin
      rx_pend <= rx_take || (rx_pend && !rx_pop);
      if (rx_take) begin
        rx_blk <= rx_blk - 7'h01;
        if (rx_blk == 7'h01) begin
          RX_DMA_REQ_CHAN_TWO <= 1'b0;
        end
      end else if (!RX_DMA_REQ_CHAN_TWO && rx_valid_int && RX_BLOCK != '0) begin
        rx_blk <= RX_BLOCK;
        RX_DMA_REQ_CHAN_TWO <= 1'b1;
      end
    end
  end
  // First-channel requests are held low in every mode; TERMINAL_EQUIPMENT_MODE is not used.
  always_ff @(posedge CLK) begin
    if (RST) begin
      TX_DMA_REQ_CHAN_ONE <= 1'b0;
      RX_DMA_REQ_CHAN_ONE <= 1'b0;
    end else if (CE) begin
      TX_DMA_REQ_CHAN_ONE <= 1'b0;
      RX_DMA_REQ_CHAN_ONE <= 1'b0;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_int_never_high: assert property (@(posedge CLK) disable iff (RST)
    INT_N_OE |-> !INT_N_OUT) else $error("interrupt line driven high");
  a_int_follows: assert property (@(posedge CLK) disable iff (RST || !CE)
    IRQ_PENDING |=> INT_N_OE) else $error("interrupt not asserted");
  a_tx_drop_last: assert property (@(posedge CLK) disable iff (RST || !CE)
    (wr_fall && dma_acc && TX_DMA_REQ_CHAN_TWO && tx_last && !TX_START)
    |=> !TX_DMA_REQ_CHAN_TWO) else $error("tx request not dropped");
  a_rx_drop_last: assert property (@(posedge CLK) disable iff (RST || !CE)
    (rx_take && rx_blk == 7'h01) |=> !RX_DMA_REQ_CHAN_TWO) else $error("rx request held");
  a_tx_idle_zero: assert property (@(posedge CLK) disable iff (RST)
    (tx_left == '0 && !$past(TX_START)) |-> !TX_DMA_REQ_CHAN_TWO)
    else $error("tx request with no bytes left");
  a_no_cs_no_reg: assert property (@(posedge CLK) disable iff (RST || !CE)
    (!selected) |=> !REG_RD) else $error("read without chip select");
  a_one_never: assert property (@(posedge CLK) disable iff (RST)
    !TX_DMA_REQ_CHAN_ONE && !RX_DMA_REQ_CHAN_ONE) else $error("channel one request");
  a_bus_one_drv: assert property (@(posedge CLK) disable iff (RST)
    !(SHARED_ADDR_DATA_LINES_OE && SEPARATE_DATA_LINES_OE)) else $error("both buses driven");
  // Access path and request levels.
  a_rd_one_pulse: assert property (@(posedge CLK) disable iff (RST || !CE)
    REG_RD |=> !REG_RD)
    else $error("read pulse longer than one cycle");
  a_wr_one_pulse: assert property (@(posedge CLK) disable iff (RST || !CE)
    REG_WR |=> !REG_WR)
    else $error("write pulse longer than one cycle");
  a_no_cs_wr: assert property (@(posedge CLK) disable iff (RST || !CE)
    !selected |=> !REG_WR)
    else $error("write without chip select");
  a_dma_no_reg: assert property (@(posedge CLK) disable iff (RST || !CE)
    dma_acc |=> !(REG_RD || REG_WR))
    else $error("register access during acknowledge");
  a_reg_addr_take: assert property (@(posedge CLK) disable iff (RST || !CE)
    (entering && !dma_acc) |=> (REG_ADDR == $past(addr)))
    else $error("register address not taken");
  a_ind_addr_low: assert property (@(posedge CLK) disable iff (RST)
    INDIRECT_MODE |-> (sep_addr[DW-1:1] == '0))
    else $error("indirect address uses upper lines");
  a_ds_end_access: assert property (@(posedge CLK) disable iff (RST || !CE)
    ((state == hbp_pkg::HBP_ACCESS) && DATA_STROBE_MODE && ds_rise) |=> (state == hbp_pkg::HBP_DONE))
    else $error("data strobe rise did not end access");
  a_ds_dir_read: assert property (@(posedge CLK) disable iff (RST || !CE)
    (DATA_STROBE_MODE && entering && selected && !dma_acc && wr_n) |=> REG_RD)
    else $error("direction high not decoded as read");
  a_mux_addr_take: assert property (@(posedge CLK) disable iff (RST || !CE)
    ale_rise |=> (mux_addr == $past(SHARED_ADDR_DATA_LINES_IN)))
    else $error("multiplexed address not latched");
  a_mux_sticky: assert property (@(posedge CLK) disable iff (RST || !CE)
    muxed |=> muxed)
    else $error("multiplexed style lost");
  a_sep_oe_read: assert property (@(posedge CLK) disable iff (RST || !CE)
    SEPARATE_DATA_LINES_OE |-> $past(rd_n_q_dir))
    else $error("data lines driven outside a read");
  a_int_quiet: assert property (@(posedge CLK) disable iff (RST || !CE)
    !IRQ_PENDING |=> !INT_N_OE)
    else $error("interrupt pulled without cause");
  a_tx_req_hold: assert property (@(posedge CLK) disable iff (RST || !CE)
    (TX_DMA_REQ_CHAN_TWO && !TX_START && !(wr_fall && dma_acc && tx_last)) |=> TX_DMA_REQ_CHAN_TWO)
    else $error("tx request dropped early");
  a_tx_blk_max: assert property (@(posedge CLK) disable iff (RST)
    tx_blk <= `HBP_BLOCK)
    else $error("tx block above limit");
  a_tx_count_down: assert property (@(posedge CLK) disable iff (RST || !CE)
    (wr_fall && dma_acc && TX_DMA_REQ_CHAN_TWO && !TX_START) |=> (tx_left == $past(tx_left) - BCW'(1)))
    else $error("tx byte count not decremented");
  a_rx_req_hold: assert property (@(posedge CLK) disable iff (RST || !CE)
    (RX_DMA_REQ_CHAN_TWO && !(rx_take && rx_blk == 7'h01)) |=> RX_DMA_REQ_CHAN_TWO)
    else $error("rx request dropped early");
  a_rx_pend_clear: assert property (@(posedge CLK) disable iff (RST || !CE)
    rx_pop |=> !rx_pend)
    else $error("rx read left pending");
  a_wr_data_take: assert property (@(posedge CLK) disable iff (RST || !CE)
    (entering && is_write) |=> (REG_WDATA == $past(data_in)))
    else $error("write data not taken");
endmodule : hbp_port

// File: core/hbp_sync.sv
// Three-stage synchroniser bank that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`include "hbp_cfg.svh"
module hbp_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire  [W-1:0] agree = ~(s2 ^ s3);
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= rst_val;
      s2 <= rst_val;
      s3 <= rst_val;
      sync_out <= rst_val;
    end else if (ce) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= (agree & s3) | (~agree & sync_out);
    end
  end
endmodule : hbp_sync

// File: sim/hbp_host.sv
// Behavioural host processor and DMA controller that drive the port's pins.
`timescale 1ns/1ps
module hbp_host (
  // Clock and lines driven by the port.
  input  wire logic       clk,
  input  wire logic [7:0] sh_out,
  input  wire logic       sh_oe,
  input  wire logic [7:0] sep_out,
  input  wire logic       sep_oe,
  // Strobes and lines driven by the host.
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            ale,
  output logic            ack_n,
  output logic [7:0]      sh_in,
  output logic [7:0]      addr,
  output logic [7:0]      sep_in
);
  logic [7:0] drv;
  logic       on_sh;
  logic       on_sep;

  // A released line shows the inverse of its last value, so stale data is never read back.
  assign sh_in  = sh_oe ? sh_out : (on_sh ? drv : ~drv);
  assign sep_in = sep_oe ? sep_out : (on_sep ? drv : ~drv);

  initial begin
    {cs_n, rd_n, wr_n, ale, ack_n} = 5'h1D;
    {on_sh, on_sep, drv, addr} = 18'h0FFFF;
  end

  // **************************************************************
  // One register or DMA access, strobe held eight cycles.
  // **************************************************************
  task automatic access(input logic mux, moto, rd, sel, dma, input logic [7:0] a, d,
                        output logic [7:0] q);
    @(negedge clk);
    addr = mux ? 8'hFF : a;
    drv = mux ? a : d;
    on_sh = mux;
    on_sep = !mux && !rd;
    ale = mux;
    repeat (6) @(negedge clk);
    ale = 1'b0;
    drv = d;
    on_sh = mux && !rd;
    cs_n = !(sel && !dma);
    ack_n = !dma;
    wr_n = moto ? rd : 1'b1;
    @(negedge clk);
    rd_n = !(moto || rd);
    wr_n = rd;
    repeat (8) @(posedge clk);
    q = mux ? sh_in : sep_in;
    @(negedge clk);
    rd_n = 1'b1;
    if (!moto) wr_n = 1'b1;
    @(negedge clk);
    {cs_n, wr_n, ack_n, on_sh, on_sep} = 5'h1C;
    repeat (8) @(negedge clk);
  endtask : access
endmodule : hbp_host

// File: sim/tb_hbp_port.sv
// Self-checking bench for the host bus port with DMA requests.
`timescale 1ns/1ps
`include "hbp_cfg.svh"
module tb_hbp_port;
  logic        clk = 1'b0, rst = 1'b1, ind = 1'b0, moto = 1'b0, te = 1'b1, irq = 1'b0;
  logic        tx_start = 1'b0, tx_ready = 1'b1, rx_valid = 1'b0, feed = 1'b0, acc = 1'b0;
  logic [7:0]  reg_rdata = 8'h00, rx_data = 8'h00, q, last_addr, last_wdata;
  logic [6:0]  rx_block = 7'h04;
  logic [11:0] tx_count = 12'h000;
  logic [31:0] seed = 32'h0365;
  logic        cs_n, rd_n, wr_n, ale, ack_n, sh_oe, sep_oe, reg_wr, reg_rd, tx_valid;
  logic        rx_ready, int_out, int_oe, txq2, rxq2, txq1, rxq1, txq2_d, rxq2_d;
  logic [7:0]  sh_in, sh_out, addr, sep_in, sep_out, reg_addr, reg_wdata, tx_data;
  logic [7:0]  tx_exp[$], tx_got[$], rx_exp[$];
  int          fail_count = 0, cmp_count = 0, n_wr = 0, n_rd = 0, tx_fall = 0, rx_fall = 0;
  int          n_acc = 0;

  hbp_port hbp_port_inst (.CLK(clk), .RST(rst), .CE(1'b1), .INDIRECT_MODE(ind),
    .DATA_STROBE_MODE(moto), .TERMINAL_EQUIPMENT_MODE(te), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .ALE(ale), .DMA_ACK_N(ack_n), .SHARED_ADDR_DATA_LINES_IN(sh_in),
    .SHARED_ADDR_DATA_LINES_OUT(sh_out), .SHARED_ADDR_DATA_LINES_OE(sh_oe),
    .SEPARATE_ADDRESS_LINES(addr), .SEPARATE_DATA_LINES_IN(sep_in),
    .SEPARATE_DATA_LINES_OUT(sep_out), .SEPARATE_DATA_LINES_OE(sep_oe), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .TX_BYTE_COUNT(tx_count), .TX_START(tx_start), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .TX_DATA(tx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
    .RX_DATA(rx_data), .RX_BLOCK(rx_block), .IRQ_PENDING(irq), .INT_N_OUT(int_out),
    .INT_N_OE(int_oe), .TX_DMA_REQ_CHAN_TWO(txq2), .RX_DMA_REQ_CHAN_TWO(rxq2),
    .TX_DMA_REQ_CHAN_ONE(txq1), .RX_DMA_REQ_CHAN_ONE(rxq1));

  hbp_host hbp_host_inst (.clk(clk), .sh_out(sh_out), .sh_oe(sh_oe), .sep_out(sep_out),
    .sep_oe(sep_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .ack_n(ack_n),
    .sh_in(sh_in), .addr(addr), .sep_in(sep_in));

  always #50 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // **************************************************************
  // Monitors on the clock and random drivers on the falling edge.
  // **************************************************************
  always @(posedge clk) begin
    if (txq2_d === 1'b1 && txq2 === 1'b0) tx_fall++;
    if (rxq2_d === 1'b1 && rxq2 === 1'b0) rx_fall++;
    txq2_d = txq2;
    rxq2_d = rxq2;
    if (reg_wr === 1'b1) last_wdata = reg_wdata;
    if (reg_wr === 1'b1 || reg_rd === 1'b1) last_addr = reg_addr;
    if (reg_wr === 1'b1) n_wr++;
    if (reg_rd === 1'b1) n_rd++;
    if (tx_valid === 1'b1 && tx_ready) tx_got.push_back(tx_data);
    acc = rx_valid && rx_ready === 1'b1;
    if (acc) rx_exp.push_back(rx_data);
    if (acc) n_acc++;
  end

  // Valid only drops once the byte was taken, as the handshake demands.
  always @(negedge clk) begin
    seed = xs(seed);
    tx_ready = seed[1:0] != 2'b00;
    if (!rx_valid || acc) rx_valid = feed && seed[2];
    if (acc || !rx_valid) rx_data = seed[15:8];
    acc = 1'b0;
  end

  task automatic check(input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic wait_hi(input logic sel_rx);
    int k;
    k = 0;
    while ((sel_rx ? rxq2 : txq2) !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) begin
      fail_count++;
      $display("wrong value at %0t: request never rose", $time);
      final_report();
    end
  endtask : wait_hi

  task automatic reg_acc(input logic mux, rd, sel, input logic [7:0] a);
    int w0, r0;
    logic [7:0] d, ea;
    w0 = n_wr;
    r0 = n_rd;
    seed = xs(seed);
    d = seed[7:0];
    reg_rdata = seed[15:8];
    ea = (ind && !mux) ? {7'h00, a[0]} : a;
    hbp_host_inst.access(mux, moto, rd, sel, 1'b0, a, d, q);
    check(16'(n_wr - w0), 16'(sel && !rd));
    check(16'(n_rd - r0), 16'(sel && rd));
    if (sel) check(16'(last_addr), 16'(ea));
    if (sel && rd) check(16'(q), 16'(reg_rdata));
    if (sel && !rd) check(16'(last_wdata), 16'(d));
  endtask : reg_acc

  task automatic dma(input logic rd, input int n, input logic [6:0] nb);
    int f0, r0;
    for (int i = 0; i < n; i++) begin
      f0 = rd ? rx_fall : tx_fall;
      r0 = n_wr + n_rd;
      seed = xs(seed);
      if (!rd) tx_exp.push_back(seed[7:0]);
      if (i == n - 1) rx_block = nb;
      hbp_host_inst.access(1'b0, 1'b0, rd, 1'b0, 1'b1, seed[15:8], seed[7:0], q);
      check(16'((rd ? rx_fall : tx_fall) - f0), 16'(i == n - 1));
      check(16'(n_wr + n_rd - r0), 16'h0000);
      if (rd) check(16'(q), 16'(rx_exp.pop_front()));
    end
  endtask : dma

  // **************************************************************
  // Main sequence.
  // **************************************************************
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    for (int m = 0; m < 4; m++) begin
      moto = m[1];
      seed = xs(seed);
      reg_acc(1'b0, m[0], 1'b1, seed[7:0]);
    end
    reg_acc(1'b0, 1'b1, 1'b0, 8'h3C);
    reg_acc(1'b0, 1'b0, 1'b0, 8'hC3);
    moto = 1'b0;
    ind = 1'b1;
    reg_acc(1'b0, 1'b0, 1'b1, 8'hA7);
    reg_acc(1'b0, 1'b1, 1'b1, 8'h5A);
    ind = 1'b0;
    irq = 1'b1;
    repeat (6) @(negedge clk);
    check(16'({int_oe, int_out}), 16'h0002);
    irq = 1'b0;
    repeat (6) @(negedge clk);
    check(16'({int_oe, int_out}), 16'h0000);
    tx_count = 12'h046;
    tx_start = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
    wait_hi(1'b0);
    dma(1'b0, 64, 7'h04);
    wait_hi(1'b0);
    dma(1'b0, 6, 7'h04);
    repeat (40) @(negedge clk);
    check(16'(txq2), 16'h0000);
    check(16'(tx_got.size()), 16'h0046);
    foreach (tx_got[i]) check(16'(tx_got[i]), 16'(tx_exp[i]));
    check(16'({txq1, rxq1}), 16'h0000);
    feed = 1'b1;
    repeat (60) @(negedge clk);
    check(16'(rx_ready), 16'h0000);
    check(16'(n_acc), 16'(`HBP_FIFO_D));
    for (int b = 4; b <= 64; b = b * 2) begin
      wait_hi(1'b1);
      dma(1'b1, b, 7'((b == 64) ? 64 : 2 * b));
    end
    feed = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rx_exp.delete();
    repeat (8) @(negedge clk);
    for (int m = 0; m < 4; m++) begin
      moto = m[1];
      seed = xs(seed);
      reg_acc(1'b1, m[0], 1'b1, seed[7:0]);
    end
    final_report();
  end
endmodule : tb_hbp_port
